// file: gpio_pair_pad_model.sv
// Purpose: pad and board model seen by the two-pin port
// Assumes: one pad per pin, resistors weak against any driver
// Notes: an undriven pad with no pull follows the board level from the bench
`timescale 1ns/1ps

module gpio_pair_pad_model (
    // control from the port
    input wire gpio_pair_pkg::pad_ctrl_t [1:0] i_pad_ctrl,
    // board level used when nothing drives and no resistor pulls
    input wire logic [1:0] i_board_level,
    // resolved pad level
    output logic [1:0] o_level
);
    // ****************************************************
    // pad resolution
    // ****************************************************
    // a driver wins over resistors; a resistor wins over the floating board
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (i_pad_ctrl[i].drive_en) begin
                o_level[i] = i_pad_ctrl[i].drive_level;
            end else if (i_pad_ctrl[i].pull_up) begin
                o_level[i] = 1'b1;
            end else if (i_pad_ctrl[i].pull_down) begin
                o_level[i] = 1'b0;
            end else begin
                o_level[i] = i_board_level[i];
            end
        end
    end
endmodule

// file: gpio_pair_pkg.sv
// Purpose: shared constants and types of the two-pin port
// Assumes: byte-addressed register port, one system clock
// Notes: the oscillator mode codes are local encodings of the clock generator
package gpio_pair_pkg;

    // ****************************************************
    // register map
    // ****************************************************
    localparam int PIN_COUNT = 2;
    localparam logic [15:0] ADDR_LEVEL_DATA = 16'hf218;
    localparam logic [15:0] ADDR_DIRECTION = 16'hf219;
    localparam logic [15:0] ADDR_DRIVE_LOW = 16'hf21a;
    localparam logic [15:0] ADDR_DRIVE_HIGH = 16'hf21b;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // ****************************************************
    // field encodings
    // ****************************************************
    // direction bit values
    localparam logic DIR_OUTPUT = 1'b0;
    localparam logic DIR_INPUT = 1'b1;
    // drive select {high bit, low bit} in output mode
    typedef enum logic [1:0] {
        DRIVE_HIZ = 2'h0,
        DRIVE_PCH_OD = 2'h1,
        DRIVE_NCH_OD = 2'h2,
        DRIVE_CMOS = 2'h3
    } drive_sel_t;
    // same bits in input mode
    typedef enum logic [1:0] {
        INPUT_HIZ = 2'h0,
        INPUT_PULL_DOWN = 2'h1,
        INPUT_PULL_UP = 2'h2,
        INPUT_HIZ_ALT = 2'h3
    } input_sel_t;
    // fast clock mode select codes from the clock generator
    localparam logic [1:0] OSC_MODE_CRYSTAL = 2'h1;
    localparam logic [1:0] OSC_MODE_EXT_CLOCK = 2'h2;
    // index of the pin that carries the oscillator output or clock input
    localparam int OSC_OUT_PIN = 1;
    // input synchroniser depth
    localparam int SYNC_STAGES = 3;

    // ****************************************************
    // pad carrier
    // ****************************************************
    typedef struct packed {
        logic drive_level; // level put on the pad
        logic drive_en; // high while the pad is driven
        logic pull_up; // pull-up resistor on
        logic pull_down; // pull-down resistor on
    } pad_ctrl_t;

endpackage

// file: gpio_pair_port.sv
// Purpose: two-pin general-purpose port with per-pin direction and drive
// Assumes: pads resolved outside; mode select comes from the system clock domain
// Notes: read data appear one cycle after the read strobe, zero otherwise
//
// Behaviour
// - one direction bit per pin, 0 output
// - output mode: hiz, P open drain, N open drain, CMOS
// - input mode: hiz, pull-down, pull-up, hiz
// - drive bits split low/high byte, word access
// - output drives data bit; data reads back written
// - input mode data read returns sampled pin
// - all registers reset to zero
// - data, direction, drive low, drive high byte addresses
// - crystal mode gives second pin to oscillator output
// - external clock uses second pin; crystal both
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps

module gpio_pair_port #(
    parameter int NUM_PINS = gpio_pair_pkg::PIN_COUNT
) (
    // clock, reset and enable
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // register port
    input wire logic [15:0] i_bus_addr,
    input wire logic [15:0] i_bus_wdata,
    input wire logic i_bus_wr,
    input wire logic i_bus_rd,
    input wire logic i_bus_word,
    output logic [15:0] o_bus_rdata,
    // clock generator mode
    input wire logic [1:0] i_fast_clock_mode_select,
    // pads
    input wire logic [NUM_PINS-1:0] i_pad_level,
    output gpio_pair_pkg::pad_ctrl_t [NUM_PINS-1:0] o_pad_ctrl,
    // oscillator hand-over
    output logic o_oscillator_out_pad_en,
    output logic o_oscillator_in_pad_en,
    output logic o_external_clock_pad_en
);

    // ****************************************************
    // register storage
    // ****************************************************
    logic [NUM_PINS-1:0] pin_level_data_reg; // written output levels
    logic [NUM_PINS-1:0] pin_direction_reg; // 1 input, 0 output
    logic [NUM_PINS-1:0] pin_drive_select_low_reg; // low drive bit per pin
    logic [NUM_PINS-1:0] pin_drive_select_high_reg; // high drive bit per pin
    logic [NUM_PINS-1:0] pin_sampled_level; // filtered pad levels
    logic [NUM_PINS-1:0] osc_claim; // pin taken by oscillator
    logic [15:0] rdata_next; // read data for the next cycle

    // ****************************************************
    // write decode
    // ****************************************************
    logic wr_data_hit; // data byte written
    logic wr_dir_hit; // direction byte written
    logic wr_low_hit; // low drive byte written
    logic wr_high_hit; // high drive byte written
    logic [7:0] wr_high_byte; // source of the high drive byte

    // byte access at each address, word access at the drive pair
    assign wr_data_hit = i_bus_wr && (i_bus_addr == gpio_pair_pkg::ADDR_LEVEL_DATA);
    assign wr_dir_hit = i_bus_wr && (i_bus_addr == gpio_pair_pkg::ADDR_DIRECTION);
    assign wr_low_hit = i_bus_wr && (i_bus_addr == gpio_pair_pkg::ADDR_DRIVE_LOW);
    // a word write at the low address fills both drive bytes
    assign wr_high_hit = i_bus_wr && ((i_bus_addr == gpio_pair_pkg::ADDR_DRIVE_HIGH)
        || ((i_bus_addr == gpio_pair_pkg::ADDR_DRIVE_LOW) && i_bus_word));
    // upper lane at the low address (word write), lower lane at the high address
    assign wr_high_byte = (i_bus_addr == gpio_pair_pkg::ADDR_DRIVE_LOW) ?
        i_bus_wdata[15:8] : i_bus_wdata[7:0];

    // ****************************************************
    // data register
    // ****************************************************
    // written even in input mode so the level is ready when switching
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            pin_level_data_reg <= '0;
        end else if (i_clk_en && wr_data_hit) begin
            pin_level_data_reg <= i_bus_wdata[NUM_PINS-1:0];
        end
    end

    // ****************************************************
    // direction register
    // ****************************************************
    // reset leaves every pin an output
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            pin_direction_reg <= '0;
        end else if (i_clk_en && wr_dir_hit) begin
            pin_direction_reg <= i_bus_wdata[NUM_PINS-1:0];
        end
    end

    // ****************************************************
    // drive select registers
    // ****************************************************
    // low byte: bit 0 of each pin's drive code
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            pin_drive_select_low_reg <= '0;
        end else if (i_clk_en && wr_low_hit) begin
            pin_drive_select_low_reg <= i_bus_wdata[NUM_PINS-1:0];
        end
    end

    // high byte: bit 1 of each pin's drive code
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            pin_drive_select_high_reg <= '0;
        end else if (i_clk_en && wr_high_hit) begin
            pin_drive_select_high_reg <= wr_high_byte[NUM_PINS-1:0];
        end
    end

    // ****************************************************
    // oscillator hand-over
    // ****************************************************
    logic mode_crystal; // crystal or ceramic oscillation chosen
    logic mode_ext_clock; // external clock input chosen

    // mode select is same-domain logic, so it is used unsynchronised
    assign mode_crystal = (i_fast_clock_mode_select == gpio_pair_pkg::OSC_MODE_CRYSTAL);
    assign mode_ext_clock = (i_fast_clock_mode_select == gpio_pair_pkg::OSC_MODE_EXT_CLOCK);

    // registered flags telling the clock generator which pads it owns
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_oscillator_out_pad_en <= 1'b0;
            o_oscillator_in_pad_en <= 1'b0;
            o_external_clock_pad_en <= 1'b0;
        end else if (i_clk_en) begin
            o_oscillator_out_pad_en <= mode_crystal;
            o_oscillator_in_pad_en <= mode_crystal;
            o_external_clock_pad_en <= mode_ext_clock;
        end
    end

    // ****************************************************
    // per-pin input sampling and pad control
    // ****************************************************
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : gen_pin
            logic [gpio_pair_pkg::SYNC_STAGES-1:0] sync_reg; // pad synchroniser
            logic level_reg; // accepted pad level
            gpio_pair_pkg::pad_ctrl_t pad_reg; // registered pad drive
            gpio_pair_pkg::pad_ctrl_t pad_next; // pad drive to register
            logic [1:0] sel; // {high, low} drive code

            assign sel = {pin_drive_select_high_reg[g], pin_drive_select_low_reg[g]};

            // the oscillator output pin also serves the clock input
            assign osc_claim[g] = mode_crystal
                || (mode_ext_clock && (g == gpio_pair_pkg::OSC_OUT_PIN));

            // three stages; stage 0 feeds only stage 1
            always_ff @(posedge i_clk_sys) begin
                if (!i_rst_n) begin
                    sync_reg <= '0;
                end else if (i_clk_en) begin
                    sync_reg <= {sync_reg[1:0], i_pad_level[g]};
                end
            end

            // a change counts once the last two stages agree
            always_ff @(posedge i_clk_sys) begin
                if (!i_rst_n) begin
                    level_reg <= 1'b0;
                end else if (i_clk_en && (sync_reg[1] == sync_reg[2])) begin
                    level_reg <= sync_reg[2];
                end
            end
            assign pin_sampled_level[g] = level_reg;

            // decode direction and drive code into pad controls
            always_comb begin
                pad_next = '0;
                if (osc_claim[g]) begin
                    // oscillator owns the pad: port drive and pulls released
                    pad_next = '0;
                end else if (pin_direction_reg[g] == gpio_pair_pkg::DIR_INPUT) begin
                    // input mode never drives, only pulls
                    case (sel)
                        gpio_pair_pkg::INPUT_PULL_DOWN: begin
                            pad_next.pull_down = 1'b1;
                        end
                        gpio_pair_pkg::INPUT_PULL_UP: begin
                            pad_next.pull_up = 1'b1;
                        end
                        default: begin
                            pad_next = '0;
                        end
                    endcase
                end else begin
                    pad_next.drive_level = pin_level_data_reg[g];
                    case (sel)
                        gpio_pair_pkg::DRIVE_PCH_OD: begin
                            // p-channel can only pull the pad high
                            pad_next.drive_en = pin_level_data_reg[g];
                        end
                        gpio_pair_pkg::DRIVE_NCH_OD: begin
                            // n-channel can only pull the pad low
                            pad_next.drive_en = ~pin_level_data_reg[g];
                        end
                        gpio_pair_pkg::DRIVE_CMOS: begin
                            pad_next.drive_en = 1'b1;
                        end
                        default: begin
                            // high-impedance output leaves the pad alone
                            pad_next.drive_en = 1'b0;
                        end
                    endcase
                end
            end

            // registered so the pad sees no decode glitches
            always_ff @(posedge i_clk_sys) begin
                if (!i_rst_n) begin
                    pad_reg <= '0;
                end else if (i_clk_en) begin
                    pad_reg <= pad_next;
                end
            end
            assign o_pad_ctrl[g] = pad_reg;
        end
    endgenerate

    // ****************************************************
    // read path
    // ****************************************************
    // per-pin choice between written value and sampled level
    logic [NUM_PINS-1:0] data_view;
    assign data_view = (pin_direction_reg & pin_sampled_level)
        | (~pin_direction_reg & pin_level_data_reg);

    // read mux; unused bits and unmapped addresses read as zero
    always_comb begin
        logic [7:0] b_data;
        logic [7:0] b_dir;
        logic [7:0] b_low;
        logic [7:0] b_high;
        b_data = '0;
        b_dir = '0;
        b_low = '0;
        b_high = '0;
        b_data[NUM_PINS-1:0] = data_view;
        b_dir[NUM_PINS-1:0] = pin_direction_reg;
        b_low[NUM_PINS-1:0] = pin_drive_select_low_reg;
        b_high[NUM_PINS-1:0] = pin_drive_select_high_reg;
        rdata_next = '0;
        if (i_bus_rd) begin
            case (i_bus_addr)
                gpio_pair_pkg::ADDR_LEVEL_DATA: begin
                    rdata_next = {8'h00, b_data};
                end
                gpio_pair_pkg::ADDR_DIRECTION: begin
                    rdata_next = {8'h00, b_dir};
                end
                gpio_pair_pkg::ADDR_DRIVE_LOW: begin
                    // a word read returns the whole pair
                    rdata_next = i_bus_word ? {b_high, b_low} : {8'h00, b_low};
                end
                gpio_pair_pkg::ADDR_DRIVE_HIGH: begin
                    rdata_next = {8'h00, b_high};
                end
                default: begin
                    rdata_next = '0;
                end
            endcase
        end
    end

    // read data stand for one cycle only, then fall back to zero
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_bus_rdata <= gpio_pair_pkg::RESET_WORD;
        end else if (i_clk_en) begin
            o_bus_rdata <= rdata_next;
        end
    end

endmodule

// file: gpio_pair_port_asserts.sv
// Purpose: port-level checks of the two-pin port
// Assumes: read data stand only the cycle after the read strobe
// Notes: sees top ports only, so register contents are tied to bus traffic
`timescale 1ns/1ps

module gpio_pair_port_asserts #(
    parameter int NUM_PINS = 2
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // register port
    input wire logic [15:0] i_bus_addr,
    input wire logic [15:0] i_bus_wdata,
    input wire logic i_bus_wr,
    input wire logic i_bus_rd,
    input wire logic i_bus_word,
    input wire logic [15:0] o_bus_rdata,
    // mode and pads
    input wire logic [1:0] i_fast_clock_mode_select,
    input wire logic [NUM_PINS-1:0] i_pad_level,
    input wire gpio_pair_pkg::pad_ctrl_t [NUM_PINS-1:0] o_pad_ctrl,
    input wire logic o_oscillator_out_pad_en,
    input wire logic o_oscillator_in_pad_en,
    input wire logic o_external_clock_pad_en
);
    // ****************************************************
    // assertions
    // ****************************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    a_rdata_idle: assert property (
        i_clk_en && !i_bus_rd |=> o_bus_rdata == 16'h0)
        else $error("read data not zero outside read");
    a_rdata_upper: assert property (
        i_clk_en && i_bus_rd
        && !(i_bus_word && i_bus_addr == gpio_pair_pkg::ADDR_DRIVE_LOW)
        |=> o_bus_rdata[15:2] == 14'h0)
        else $error("byte read has stray upper bits");
    a_reset_clear: assert property (
        disable iff (1'b0) !i_rst_n |=> o_pad_ctrl == '0
        && o_bus_rdata == 16'h0 && !o_oscillator_out_pad_en)
        else $error("outputs not cleared by reset");
    a_crystal_claim: assert property (
        i_clk_en && i_fast_clock_mode_select == gpio_pair_pkg::OSC_MODE_CRYSTAL
        |=> o_oscillator_out_pad_en && o_oscillator_in_pad_en && o_pad_ctrl == '0)
        else $error("crystal mode did not claim both pads");
    a_extclk_claim: assert property (
        i_clk_en && i_fast_clock_mode_select == gpio_pair_pkg::OSC_MODE_EXT_CLOCK
        |=> o_external_clock_pad_en && !o_oscillator_out_pad_en && o_pad_ctrl[1] == '0)
        else $error("external clock mode did not claim second pad");
    a_pull_alone: assert property (
        !(o_pad_ctrl[0].drive_en
        && (o_pad_ctrl[0].pull_up || o_pad_ctrl[0].pull_down)))
        else $error("pad driven with a resistor on");
    a_dir_readback: assert property (
        i_clk_en && i_bus_wr
        && i_bus_addr == gpio_pair_pkg::ADDR_DIRECTION ##1 i_clk_en && !i_bus_wr ##1 i_clk_en
        && i_bus_rd && i_bus_addr == gpio_pair_pkg::ADDR_DIRECTION
        |=> o_bus_rdata == {14'h0, $past(i_bus_wdata[1:0], 3)})
        else $error("direction read differs from write");
    a_word_readback: assert property (
        i_clk_en && i_bus_wr && i_bus_word
        && i_bus_addr == gpio_pair_pkg::ADDR_DRIVE_LOW ##1 i_clk_en && !i_bus_wr ##1 i_clk_en
        && i_bus_rd && i_bus_word && i_bus_addr == gpio_pair_pkg::ADDR_DRIVE_LOW
        |=> {o_bus_rdata[9:8], o_bus_rdata[1:0]}
        == {$past(i_bus_wdata[9:8], 3), $past(i_bus_wdata[1:0], 3)})
        else $error("drive word read differs from write");
    // pads only move after a write or a mode change
    a_pad_steady: assert property (
        (!i_bus_wr && i_clk_en && i_fast_clock_mode_select == 2'h0)[*2]
        |=> $stable(o_pad_ctrl))
        else $error("pad control moved without a write");
endmodule

bind gpio_pair_port gpio_pair_port_asserts #(.NUM_PINS(NUM_PINS)) u_asserts (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
    .i_bus_addr(i_bus_addr), .i_bus_wdata(i_bus_wdata), .i_bus_wr(i_bus_wr),
    .i_bus_rd(i_bus_rd), .i_bus_word(i_bus_word), .o_bus_rdata(o_bus_rdata),
    .i_fast_clock_mode_select(i_fast_clock_mode_select), .i_pad_level(i_pad_level),
    .o_pad_ctrl(o_pad_ctrl), .o_oscillator_out_pad_en(o_oscillator_out_pad_en),
    .o_oscillator_in_pad_en(o_oscillator_in_pad_en),
    .o_external_clock_pad_en(o_external_clock_pad_en)
);

// file: tb_two_pin_port_direction_drive.sv
// Purpose: self-checking bench of the two-pin port
// Assumes: pads resolved by the pad model, bench drives at rising edges
// Notes: pad inputs need several cycles to pass the synchroniser
`timescale 1ns/1ps

module tb_two_pin_port_direction_drive;
    // ****************************************************
    // signals
    // ****************************************************
    logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, wr = 1'b0, rd = 1'b0, word = 1'b0;
    logic [15:0] addr = 16'h0, wdata = 16'h0, rdata, rv;
    logic [1:0] mode = 2'h0, board = 2'h2, pads;
    logic osc_out, osc_in, ext_en;
    gpio_pair_pkg::pad_ctrl_t [1:0] pad_ctrl;
    int fail_count = 0, n_tests = 0;

    gpio_pair_port DUT (.i_clk_sys(clk), .i_rst_n(rst_n), .i_clk_en(clk_en),
        .i_bus_addr(addr), .i_bus_wdata(wdata), .i_bus_wr(wr), .i_bus_rd(rd),
        .i_bus_word(word), .o_bus_rdata(rdata), .i_fast_clock_mode_select(mode),
        .i_pad_level(pads), .o_pad_ctrl(pad_ctrl), .o_oscillator_out_pad_en(osc_out),
        .o_oscillator_in_pad_en(osc_in), .o_external_clock_pad_en(ext_en));
    gpio_pair_pad_model pad_board (.i_pad_ctrl(pad_ctrl), .i_board_level(board), .o_level(pads));

    initial begin
        forever #10 clk = ~clk;
    end

    // ****************************************************
    // shared tasks
    // ****************************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus_wr(input logic [15:0] a, input logic [15:0] d, input logic w);
        @(posedge clk);
        addr <= a; wdata <= d; word <= w; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0; word <= 1'b0;
    endtask
    task automatic bus_rd(input logic [15:0] a, input logic w);
        @(posedge clk);
        addr <= a; word <= w; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0; word <= 1'b0;
        @(negedge clk);
        rv = rdata;
    endtask
    // expected pad nibble {level, drive, pull up, pull down} of one pin
    function automatic logic [3:0] exp_pad(input logic dir, input logic [1:0] c, input logic d);
        if (dir) return {2'b00, c == 2'h2, c == 2'h1};
        return {d, c == 2'h3 || (c == 2'h1 && d) || (c == 2'h2 && !d), 2'b00};
    endfunction
    task automatic print_verdict();
        if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ****************************************************
    // scenarios
    // ****************************************************
    task automatic t_reset();
        for (int i = 0; i < 4; i++) begin
            bus_rd(16'hf218 + 16'(i), 1'b0);
            chk(rv, 16'h0);
        end
        chk({8'h0, pad_ctrl}, 16'h0);
    endtask
    // every output drive code with both data levels, pins set opposite
    task automatic t_output();
        for (int c = 0; c < 4; c++) begin
            for (int d = 0; d < 2; d++) begin
                bus_wr(gpio_pair_pkg::ADDR_DRIVE_LOW, {14'h0, {2{c[0]}}}, 1'b0);
                bus_wr(gpio_pair_pkg::ADDR_DRIVE_HIGH, {14'h0, {2{c[1]}}}, 1'b0);
                bus_wr(gpio_pair_pkg::ADDR_LEVEL_DATA, {14'h0, !d[0], d[0]}, 1'b0);
                repeat (2) @(negedge clk);
                chk({8'h0, pad_ctrl},
                    {8'h0, exp_pad(0, c[1:0], !d[0]), exp_pad(0, c[1:0], d[0])});
                bus_rd(gpio_pair_pkg::ADDR_LEVEL_DATA, 1'b0);
                chk(rv, {14'h0, !d[0], d[0]});
            end
        end
    endtask
    // every input code; pad level comes back through the data register
    task automatic t_input();
        bus_wr(gpio_pair_pkg::ADDR_DIRECTION, 16'h00ff, 1'b0);
        bus_rd(gpio_pair_pkg::ADDR_DIRECTION, 1'b0);
        chk(rv, 16'h0003);
        for (int c = 0; c < 4; c++) begin
            bus_wr(gpio_pair_pkg::ADDR_DRIVE_LOW, {6'h0, {2{c[1]}}, 6'h0, {2{c[0]}}}, 1'b1);
            bus_rd(gpio_pair_pkg::ADDR_DRIVE_LOW, 1'b1);
            chk(rv, {6'h0, {2{c[1]}}, 6'h0, {2{c[0]}}});
            bus_rd(gpio_pair_pkg::ADDR_DRIVE_HIGH, 1'b0);
            chk(rv, {14'h0, {2{c[1]}}});
            repeat (6) @(negedge clk);
            chk({8'h0, pad_ctrl}, {8'h0, {2{exp_pad(1, c[1:0], 1'b0)}}});
            bus_rd(gpio_pair_pkg::ADDR_LEVEL_DATA, 1'b0);
            chk(rv, c == 1 ? 16'h0 : c == 2 ? 16'h3 : 16'h2);
        end
    endtask
    task automatic t_osc();
        bus_wr(gpio_pair_pkg::ADDR_DIRECTION, 16'h0, 1'b0);
        bus_wr(gpio_pair_pkg::ADDR_DRIVE_LOW, 16'h0303, 1'b1);
        bus_wr(gpio_pair_pkg::ADDR_LEVEL_DATA, 16'h3, 1'b0);
        @(posedge clk);
        mode <= gpio_pair_pkg::OSC_MODE_CRYSTAL;
        repeat (2) @(negedge clk);
        chk({osc_out, osc_in, ext_en, 5'h0, pad_ctrl}, 16'hc000);
        @(posedge clk);
        mode <= gpio_pair_pkg::OSC_MODE_EXT_CLOCK;
        repeat (2) @(negedge clk);
        chk({osc_out, osc_in, ext_en, 5'h0, pad_ctrl}, 16'h200c);
        @(posedge clk);
        mode <= 2'h0;
        repeat (2) @(negedge clk);
        chk({8'h0, pad_ctrl}, 16'h00cc);
    endtask
    // unmapped place, and a write while the clock enable is low
    task automatic t_map();
        bus_wr(16'hf21c, 16'h00ff, 1'b0);
        bus_rd(16'hf21c, 1'b0);
        chk(rv, 16'h0);
        @(posedge clk);
        clk_en <= 1'b0;
        bus_wr(gpio_pair_pkg::ADDR_DIRECTION, 16'h0003, 1'b0);
        clk_en <= 1'b1;
        bus_rd(gpio_pair_pkg::ADDR_DIRECTION, 1'b0);
        chk(rv, 16'h0);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_output();
        t_input();
        t_osc();
        t_map();
        print_verdict();
    end
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        print_verdict();
    end
endmodule
